// ==== logic/fsp_flash_status.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsp_flash_status #(
  parameter int                 WSR_CYCLES = fsp_pkg::STATUS_WRITE_CYCLES,
  parameter fsp_pkg::fsp_prot_t PROT_START = fsp_pkg::PROT_START_DEFAULT
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              spiSck,
  input  wire logic              spiCsn,
  input  wire logic              serialInPin,
  output logic                   serialOutPin,
  output logic                   serialOutEn,
  input  wire logic              writeProtectN,
  output logic                   memRdEn,
  output fsp_pkg::fsp_addr_t     memRdAddr,
  input  wire logic              memDataValid,
  input  wire logic [7:0]        memData,
  output logic                   memRdReady,
  input  wire logic              arrayBusy,
  output logic                   cmdProgram,
  output logic                   cmdSectorErase,
  output logic                   cmdBulkErase,
  output fsp_pkg::fsp_addr_t     cmdAddr
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]           sync1;
    logic [3:0]           sync2;
    logic                 sckPrev;
    logic                 csnPrev;
    logic                 arrayBusyPrev;
    fsp_state_t           state;
    logic [2:0]           bitCnt;
    logic [2:0]           byteCnt;
    logic [2:0]           outBitCnt;
    logic [7:0]           opcode;
    logic [23:0]          inShift;
    logic [7:0]           outShift;
    logic                 serialOut;
    logic                 serialOutEn;
    logic                 memRdEn;
    fsp_addr_t            memRdAddr;
    fsp_addr_t            cmdAddr;
    logic                 latch;
    logic                 lock;
    logic [2:0]           level;
    logic                 wsrBusy;
    logic [WSR_CNT_W-1:0] wsrCount;
    logic                 pendLock;
    logic [1:0]           pendLevel;
    logic                 cmdProgram;
    logic                 cmdSectorErase;
    logic                 cmdBulkErase;
  } fsp_st_t;

  fsp_st_t     s;
  fsp_st_t     n;
  logic        selected;
  logic        sckRise;
  logic        sckFall;
  logic        frameEnd;
  logic        onBoundary;
  logic        busyNow;
  logic        hardLock;
  logic        wsrAccept;
  logic        popByte;
  logic        bufInReady;
  logic        bufOutValid;
  logic [7:0]  bufOutData;
  logic [23:0] shifted;
  logic [2:0]  newByteCnt;
  logic [7:0]  loadByte;

  // Only second-stage values feed the logic
  assign selected   = ~s.sync2[SY_CSN];
  assign sckRise    = s.sync2[SY_SCK] & ~s.sckPrev;
  assign sckFall    = ~s.sync2[SY_SCK] & s.sckPrev;
  assign frameEnd   = s.sync2[SY_CSN] & ~s.csnPrev;
  assign onBoundary = (s.bitCnt == 3'h0);
  assign busyNow    = s.wsrBusy | arrayBusy;
  assign hardLock   = s.lock & ~s.sync2[SY_WPN];
  // Pin and lock sampled at the frame end that decodes the write
  assign wsrAccept  = frameEnd && onBoundary && (s.opcode == OP_WRITE_STATUS)
                      && (s.byteCnt == BYTES_STATUS_WRITE)
                      && s.latch && !busyNow && !hardLock;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n                = s;
    popByte          = 1'b0;
    shifted          = {s.inShift[22:0], s.sync2[SY_SDI]};
    newByteCnt       = s.byteCnt;
    loadByte         = FILL_BYTE;
    n.sync1          = {writeProtectN, serialInPin, spiCsn, spiSck};
    n.sync2          = s.sync1;
    n.sckPrev        = s.sync2[SY_SCK];
    n.csnPrev        = s.sync2[SY_CSN];
    n.arrayBusyPrev  = arrayBusy;
    n.cmdProgram     = 1'b0;
    n.cmdSectorErase = 1'b0;
    n.cmdBulkErase   = 1'b0;

    if (s.wsrBusy) begin
      if (s.wsrCount == WSR_CNT_W'(1)) begin
        n.wsrBusy  = 1'b0;
        n.latch    = 1'b0;
        n.lock     = s.pendLock;
        n.level    = {s.level[2], s.pendLevel};
      end else begin
        n.wsrCount = s.wsrCount - WSR_CNT_W'(1);
      end
    end
    if (s.arrayBusyPrev && !arrayBusy) begin
      n.latch = 1'b0;
    end
    if (s.memRdEn && memDataValid && bufInReady) begin
      n.memRdAddr = s.memRdAddr + 24'h000001;
    end

    if (!selected) begin
      if (frameEnd && onBoundary && !busyNow) begin
        if (s.byteCnt == BYTES_OPCODE && s.opcode == OP_WRITE_ENABLE) begin
          n.latch = 1'b1;
        end
        if (s.byteCnt == BYTES_OPCODE && s.opcode == OP_WRITE_DISABLE) begin
          n.latch = 1'b0;
        end
        if (s.latch && s.opcode == OP_PROGRAM && s.byteCnt >= BYTES_PROGRAM_MIN
            && !fsp_is_protected(PROT_START, s.level, s.cmdAddr)) begin
          n.cmdProgram = 1'b1;
        end
        if (s.latch && s.opcode == OP_SECTOR_ERASE && s.byteCnt == BYTES_ADDR_HDR
            && !fsp_is_protected(PROT_START, s.level, s.cmdAddr)) begin
          n.cmdSectorErase = 1'b1;
        end
        if (s.latch && s.opcode == OP_BULK_ERASE && s.byteCnt == BYTES_OPCODE
            && s.level == 3'h0) begin
          n.cmdBulkErase = 1'b1;
        end
      end
      if (wsrAccept) begin
        n.wsrBusy   = 1'b1;
        n.wsrCount  = WSR_CNT_W'(WSR_CYCLES);
        n.pendLock  = s.inShift[SB_LOCK];
        n.pendLevel = {s.inShift[SB_LEVEL1], s.inShift[SB_LEVEL0]};
      end
      n.state       = ST_IDLE;
      n.bitCnt      = 3'h0;
      n.byteCnt     = 3'h0;
      n.outBitCnt   = 3'h0;
      n.serialOutEn = 1'b0;
      n.memRdEn     = 1'b0;
    end else begin
      if (s.state == ST_IDLE) begin
        n.state = ST_CMD;
      end
      if (sckRise && (s.state == ST_IDLE || s.state == ST_CMD)) begin
        n.inShift = shifted;
        n.bitCnt  = s.bitCnt + 3'h1;
        if (s.bitCnt == BIT_LAST) begin
          if (s.byteCnt != BYTES_SATURATE) begin
            newByteCnt = s.byteCnt + 3'h1;
          end
          n.byteCnt = newByteCnt;
          if (newByteCnt == BYTES_OPCODE) begin
            n.opcode = shifted[7:0];
            if (shifted[7:0] == OP_READ_STATUS) begin
              n.state       = ST_STATUS;
              n.serialOutEn = 1'b1;
            end
          end
          if (newByteCnt == BYTES_ADDR_HDR) begin
            n.cmdAddr = shifted;
            if (s.opcode == OP_READ && !busyNow) begin
              n.state       = ST_READ;
              n.serialOutEn = 1'b1;
              n.memRdEn     = 1'b1;
              n.memRdAddr   = shifted;
            end
          end
        end
      end
      if (sckFall && (s.state == ST_STATUS || s.state == ST_READ)) begin
        n.outBitCnt = s.outBitCnt + 3'h1;
        if (s.outBitCnt == 3'h0) begin
          if (s.state == ST_STATUS) begin
            // Resampled every byte so polling sees busy drop
            loadByte = fsp_status_byte(s.lock, s.level, s.latch, busyNow);
          end else if (bufOutValid) begin
            loadByte = bufOutData;
            popByte  = 1'b1;
          end
          n.serialOut = loadByte[7];
          n.outShift  = {loadByte[6:0], 1'b0};
        end else begin
          n.serialOut = s.outShift[7];
          n.outShift  = {s.outShift[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.sync1 <= SYNC_RESET;
      s.sync2 <= SYNC_RESET;
      s.csnPrev <= 1'b1;
      s.lock  <= LOCK_RESET;
      s.level <= LEVEL_RESET;
    end else if (ce) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  fsp_buf2 #(
    .W(8)
  ) u_buf (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .flush    (!s.memRdEn),
    .inValid  (memDataValid & s.memRdEn),
    .inData   (memData),
    .inReady  (bufInReady),
    .outValid (bufOutValid),
    .outData  (bufOutData),
    .outReady (popByte)
  );

  assign serialOutPin   = s.serialOut;
  assign serialOutEn    = s.serialOutEn;
  assign memRdEn        = s.memRdEn;
  assign memRdAddr      = s.memRdAddr;
  assign memRdReady     = bufInReady;
  assign cmdProgram     = s.cmdProgram;
  assign cmdSectorErase = s.cmdSectorErase;
  assign cmdBulkErase   = s.cmdBulkErase;
  assign cmdAddr        = s.cmdAddr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence wsrStartSeq;
    ce && wsrAccept;
  endsequence
  sequence wsrHeldSeq;
    s.wsrBusy [*8];
  endsequence

  chk_wsr_busy_start: assert property (wsrStartSeq |=> wsrHeldSeq)
    else $error("status write did not hold busy");
  chk_wsr_no_latch: assert property ($rose(s.wsrBusy) |-> $past(s.latch))
    else $error("status write started without latch");
  chk_wsr_hard_lock: assert property ($rose(s.wsrBusy) |-> !$past(hardLock))
    else $error("status write accepted under hard lock");
  chk_lock_stable: assert property ((ce && hardLock && !s.wsrBusy) |=> $stable({s.lock, s.level}))
    else $error("locked status bits changed");
  chk_wsr_end_clear: assert property ((ce && s.wsrBusy && s.wsrCount == WSR_CNT_W'(1))
                                      |=> !s.wsrBusy && !s.latch)
    else $error("status write end did not clear latch");
  chk_bulk_level: assert property ($rose(s.cmdBulkErase) |-> s.level == 3'h0 && $past(s.latch))
    else $error("bulk erase with protection set");
  chk_prog_protect: assert property ((s.cmdProgram || s.cmdSectorErase)
                                     |-> !fsp_is_protected(PROT_START, s.level, s.cmdAddr))
    else $error("protected area command issued");
  chk_read_busy: assert property ($rose(s.memRdEn) |-> !$past(busyNow))
    else $error("array read started while busy");
  chk_addr_wrap: assert property ((ce && s.memRdEn && memDataValid && bufInReady
                                   && s.memRdAddr == 24'hffffff && selected) |=> s.memRdAddr == 24'h000000)
    else $error("read address did not wrap");
  chk_cs_stops_out: assert property ((ce && !selected) |=> (!s.serialOutEn && !s.memRdEn))
    else $error("output still driven after deselect");

endmodule
`default_nettype wire

// ==== logic/fsp_pkg.sv ====
`default_nettype none
package fsp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ         = 20;
  // Self-timed status write length, plain default
  localparam int STATUS_WRITE_TIME_US = 5000;
  localparam int STATUS_WRITE_CYCLES  = STATUS_WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int WSR_CNT_W            = 24;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_PROGRAM       = 8'h02;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_BULK_ERASE    = 8'hc7;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'hd8;

  // ----------------------------------------------------------------
  // Frame byte counts
  // ----------------------------------------------------------------
  localparam logic [2:0] BYTES_OPCODE       = 3'h1;
  localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
  localparam logic [2:0] BYTES_ADDR_HDR     = 3'h4;
  localparam logic [2:0] BYTES_PROGRAM_MIN  = 3'h5;
  localparam logic [2:0] BYTES_SATURATE     = 3'h7;
  localparam logic [2:0] BIT_LAST           = 3'h7;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int SB_LOCK   = 7;
  localparam int SB_LEVEL1 = 3;
  localparam int SB_LEVEL0 = 2;
  localparam int SB_LATCH  = 1;
  localparam int SB_BUSY   = 0;
  localparam logic       LOCK_RESET  = 1'b0;
  localparam logic [2:0] LEVEL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SY_SCK = 0;
  localparam int SY_CSN = 1;
  localparam int SY_SDI = 2;
  localparam int SY_WPN = 3;
  localparam logic [3:0] SYNC_RESET = 4'ha;

  localparam logic [7:0] FILL_BYTE      = 8'hff;
  localparam logic [1:0] BUF_FULL_COUNT = 2'h2;

  typedef logic [23:0]       fsp_addr_t;
  typedef logic [7:0][23:0]  fsp_prot_t;
  localparam fsp_prot_t PROT_START_DEFAULT = {24'h000000, 24'h000000, 24'h000000, 24'h000000,
                                              24'h040000, 24'h060000, 24'h070000, 24'h000000};

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_STATUS, ST_READ} fsp_state_t;

  function automatic logic [7:0] fsp_status_byte(input logic lock, input logic [2:0] level,
                                                 input logic latch, input logic busy);
    logic [7:0] b;
    b            = 8'h00;
    b[SB_LOCK]   = lock;
    b[SB_LEVEL1] = level[1];
    b[SB_LEVEL0] = level[0];
    b[SB_LATCH]  = latch;
    b[SB_BUSY]   = busy;
    return b;
  endfunction

  function automatic logic fsp_is_protected(input fsp_prot_t starts, input logic [2:0] level,
                                            input fsp_addr_t addr);
    return (level != 3'h0) && (addr >= starts[level]);
  endfunction

endpackage
`default_nettype wire

// ==== logic/fsp_buf2.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsp_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  import fsp_pkg::*;

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wrPtr;
    logic              rdPtr;
    logic [1:0]        count;
    logic              room;
  } fsp_buf_st_t;

  fsp_buf_st_t s;
  fsp_buf_st_t n;
  logic        push;
  logic        pop;

  always_comb begin
    n    = s;
    push = inValid & s.room;
    pop  = outReady & (s.count != 2'h0);
    if (flush) begin
      n.wrPtr = 1'b0;
      n.rdPtr = 1'b0;
      n.count = 2'h0;
      n.room  = 1'b1;
    end else begin
      if (push) begin
        n.mem[s.wrPtr] = inData;
        n.wrPtr        = ~s.wrPtr;
      end
      if (pop) begin
        n.rdPtr = ~s.rdPtr;
      end
      n.count = s.count + {1'b0, push} - {1'b0, pop};
      // Ready held in its own flop so the array sees a clean level
      n.room  = (n.count != BUF_FULL_COUNT);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s      <= '0;
      s.room <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign inReady  = s.room;
  assign outValid = (s.count != 2'h0);
  assign outData  = s.mem[s.rdPtr];

endmodule
`default_nettype wire

// ==== test/fsp_spi_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsp_spi_host (
  input  wire logic clk,
  output logic      spiSck,
  output logic      spiCsn,
  output logic      serialInPin,
  input  wire logic serialOutPin
);
  // ------------------------------------------------------------
  // Mode 0 host, 400 ns link period, clock idle low between frames
  // ------------------------------------------------------------
  localparam int HALF = 4;
  initial begin
    spiSck = 1'b0;
    spiCsn = 1'b1;
    serialInPin = 1'b0;
  end
  // Sends ntx bytes of tx, then clocks in nrd bytes
  task automatic frame(input logic [39:0] tx, input int ntx, input int nrd, output logic [31:0] rx);
    logic [7:0] b;
    rx = '0;
    @(negedge clk);
    spiCsn = 1'b0;
    for (int i = 0; i < ntx + nrd; i++) begin
      b = (i < ntx) ? tx[8*(ntx-1-i) +: 8] : 8'h00;
      for (int k = 7; k >= 0; k--) begin
        spiSck = 1'b0;
        serialInPin = b[k];
        repeat (HALF) @(negedge clk);
        spiSck = 1'b1;
        repeat (HALF) @(negedge clk);
        b[k] = serialOutPin;
      end
      if (i >= ntx) rx = {rx[23:0], b};
    end
    spiSck = 1'b0;
    repeat (HALF) @(negedge clk);
    // Select raised half a link period after the clock falls following the last bit
    spiCsn = 1'b1;
    // Released line must not keep the last bit
    serialInPin = ~serialInPin;
    repeat (8) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fsp_pkg::*;
  localparam int WSR = 400;
  logic       clk, rstn, writeProtectN, memDataValid, arrayBusy, spiSck, spiCsn, serialInPin;
  logic       serialOutPin, serialOutEn, memRdEn, memRdReady, cmdProgram, cmdSectorErase, cmdBulkErase;
  logic       oeSeen, readyLow, ce;
  logic [7:0] memData;
  logic [31:0] rx;
  fsp_addr_t  memRdAddr, cmdAddr;
  int         badCount, checkCount, pulses, busyLeft;

  fsp_flash_status #(.WSR_CYCLES(WSR)) fsp_flash_status_i (
    .clk(clk), .rstn(rstn), .ce(ce), .spiSck(spiSck), .spiCsn(spiCsn), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin), .serialOutEn(serialOutEn), .writeProtectN(writeProtectN),
    .memRdEn(memRdEn), .memRdAddr(memRdAddr), .memDataValid(memDataValid), .memData(memData),
    .memRdReady(memRdReady), .arrayBusy(arrayBusy), .cmdProgram(cmdProgram),
    .cmdSectorErase(cmdSectorErase), .cmdBulkErase(cmdBulkErase), .cmdAddr(cmdAddr));
  fsp_spi_host fsp_spi_host_i (.clk(clk), .spiSck(spiSck), .spiCsn(spiCsn), .serialInPin(serialInPin),
    .serialOutPin(serialOutPin));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Array and erase engine; busy long enough to overlap a read frame
  // ------------------------------------------------------------
  always @(negedge clk) begin
    memData <= memRdAddr[7:0] + memRdAddr[23:16];
    if (cmdProgram | cmdSectorErase | cmdBulkErase) begin
      pulses <= pulses + 1;
      busyLeft <= 600;
    end else if (busyLeft > 0) busyLeft <= busyLeft - 1;
    arrayBusy <= (busyLeft > 1);
    if (serialOutEn) oeSeen <= 1'b1;
    if (!memRdReady) readyLow <= 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [39:0] tx, input int ntx, input int nrd = 0);
    fsp_spi_host_i.frame(tx, ntx, nrd, rx);
  endtask
  task automatic status(input logic [7:0] exp, input logic [7:0] mask = 8'hff);
    xfer(40'h05, 1, 1);
    check(rx[7:0] & mask, exp);
  endtask
  task automatic wsr(input logic [7:0] d);
    xfer({32'h0, 8'h06}, 1);
    xfer({24'h0, 8'h01, d}, 2);
    repeat (WSR + 50) @(negedge clk);
  endtask
  task automatic cmd(input logic [39:0] tx, input int ntx, input int exp, input fsp_addr_t a);
    int p0;
    p0 = pulses;
    xfer({32'h0, 8'h06}, 1);
    xfer(tx, ntx);
    check(pulses - p0, exp);
    if (exp == 1) check(cmdAddr, a);
    repeat (650) @(negedge clk);
  endtask

  task automatic t_reset();
    check({memRdReady, serialOutEn, memRdEn}, 3'h4);
    status(8'h00);
    // Frozen block must miss a whole frame
    ce = 1'b0;
    xfer({32'h0, 8'h06}, 1);
    ce = 1'b1;
    status(8'h00);
  endtask
  task automatic t_latch();
    xfer({32'h0, 8'h06}, 1);
    status(8'h02);
    xfer({32'h0, 8'h04}, 1);
    status(8'h00);
    xfer({24'h0, 8'h01, 8'h8c}, 2);
    repeat (WSR + 50) @(negedge clk);
    status(8'h00);
  endtask
  task automatic t_wsr();
    xfer({32'h0, 8'h06}, 1);
    xfer({24'h0, 8'h01, 8'hff}, 2);
    status(8'h03);
    repeat (WSR) @(negedge clk);
    status(8'h8c);
  endtask
  task automatic t_modes();
    writeProtectN = 1'b0;
    wsr(8'h00);
    status(8'h8c, 8'hfd);
    writeProtectN = 1'b1;
    wsr(8'h0c);
    status(8'h0c);
    xfer({32'h0, 8'h06}, 1);
    xfer({16'h0, 8'h01, 16'h0}, 3);
    repeat (WSR + 50) @(negedge clk);
    status(8'h0e);
    writeProtectN = 1'b0;
    xfer({24'h0, 8'h01, 8'h0c}, 2);
    repeat (WSR + 50) @(negedge clk);
    status(8'h0c);
    wsr(8'h8c);
    status(8'h8c);
    wsr(8'h00);
    status(8'h8e);
    writeProtectN = 1'b1;
  endtask
  task automatic t_protect();
    cmd({8'h0, 32'hd8050000}, 4, 0, 24'h0);
    cmd({8'h0, 32'hd8010000}, 4, 1, 24'h010000);
    cmd({32'h0, 8'hc7}, 1, 0, 24'h0);
    cmd({40'h0203ff0055}, 5, 1, 24'h03ff00);
    cmd({40'h0204000055}, 5, 0, 24'h0);
    wsr(8'h00);
    cmd({32'h0, 8'hc7}, 1, 1, 24'h040000);
  endtask
  task automatic t_read();
    xfer({32'h0, 8'h06}, 1);
    xfer({8'h0, 32'hd8010000}, 4);
    oeSeen = 1'b0;
    xfer({8'h0, 32'h03000010}, 4, 1);
    check({oeSeen, memRdEn}, 2'h0);
    status(8'h01, 8'h01);
    repeat (650) @(negedge clk);
    readyLow = 1'b0;
    xfer({8'h0, 32'h03fffffe}, 4, 4);
    check(rx, 32'hfdfe0001);
    check(readyLow, 1'b1);
    check({serialOutEn, memRdEn}, 2'h0);
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #2000000;
    badCount++;
    finalReport();
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    writeProtectN = 1'b1;
    memDataValid = 1'b1;
    memData = 8'h00;
    arrayBusy = 1'b0;
    {badCount, checkCount, pulses, busyLeft} = '0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_latch();
    t_wsr();
    t_modes();
    t_protect();
    t_read();
    finalReport();
  end
endmodule
`default_nettype wire
